// *** rtl/sbl_top.sv ***
// Baud generator, line format, routing and event interrupts of the UART
`timescale 1ns/1ps
module sbl_top (
   input  wire logic       MCLK,
   input  wire logic       RSTN,
   input  wire logic [2:0] ADDR,
   input  wire logic [7:0] WDATA,
   input  wire logic       WR,
   input  wire logic       RD,
   output logic      [7:0] RDATA,
   output logic            IRQ,
   input  wire logic       WAIT_MODE,
   input  wire logic       LIN_BREAK_EVT,
   input  wire logic       RXD_PIN,
   input  wire logic       TXD_PIN_IN,
   output logic            TXD_OUT,
   output logic            TXD_OE_N,
   input  wire logic       TX_SER,
   output logic            RX_SER,
   output logic            BAUD_TICK,
   output logic            BIT_TICK,
   output logic            NINE_BIT,
   output logic            WAKE_ADDR,
   output logic            TX_ON,
   output logic            RX_ON,
   input  wire logic [8:0] TX_DATA,
   output logic      [8:0] TX_CHAR,
   input  wire logic [8:0] RX_CHAR,
   output logic            PARITY_ERR,
   input  wire logic       RX_FRAME_END,
   output logic            IDLE_DET
);
   typedef enum logic {SBL_IDLE_WAIT, SBL_IDLE_COUNT} sbl_idle_e;

   logic [7:0]  bdh_r;
   logic [7:0]  bdh_hold_r;
   logic [7:0]  bdl_r;
   logic [7:0]  fmt_r;
   logic [7:0]  ena_r;
   logic [1:0]  ien_r;
   logic [1:0]  stat_r;
   logic [1:0]  stat_nxt;
   logic [1:0]  evt;
   logic [1:0]  gate;
   logic [7:0]  rdata_r;
   logic        armed_r;
   logic [12:0] div;
   logic [12:0] cnt_r;
   logic [3:0]  sub_r;
   logic        run;
   logic        tick;
   logic        rx_prev_r;
   logic [8:0]  tx_char_r;
   logic        perr_r;
   logic        loop;
   logic        single;
   logic        frozen;
   sbl_idle_e   idle_st_r;
   logic [3:0]  idle_cnt_r;
   logic [3:0]  idle_target;
   logic        idle_r;
   logic        wr_bdh;
   logic        wr_bdl;
   logic        wr_fmt;
   logic        wr_ena;
   logic        wr_clr;
   logic        wr_ien;

   // ======================================================
   // Register decode
   // ======================================================
   always_comb begin
      wr_bdh = 1'b0;
      wr_bdl = 1'b0;
      wr_fmt = 1'b0;
      wr_ena = 1'b0;
      wr_clr = 1'b0;
      wr_ien = 1'b0;
      if (WR && ADDR == sbl_pkg::OFF_BDH) begin
         wr_bdh = 1'b1;
      end else if (WR && ADDR == sbl_pkg::OFF_BDL) begin
         wr_bdl = 1'b1;
      end else if (WR && ADDR == sbl_pkg::OFF_FMT) begin
         wr_fmt = 1'b1;
      end else if (WR && ADDR == sbl_pkg::OFF_ENA) begin
         wr_ena = 1'b1;
      end else if (WR && ADDR == sbl_pkg::OFF_CLR) begin
         wr_clr = 1'b1;
      end else if (WR && ADDR == sbl_pkg::OFF_IEN) begin
         wr_ien = 1'b1;
      end
   end

   // Enable bits of the upper byte act at once; only the
   // divisor half waits for the lower byte.
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         bdh_r      <= sbl_pkg::RST_BDH;
         bdh_hold_r <= sbl_pkg::RST_BDH;
         bdl_r      <= sbl_pkg::RST_BDL;
      end else if (wr_bdh) begin
         bdh_hold_r <= WDATA & sbl_pkg::BDH_WMASK;
         bdh_r[sbl_pkg::BDH_BRK_IE]  <= WDATA[sbl_pkg::BDH_BRK_IE];
         bdh_r[sbl_pkg::BDH_EDGE_IE] <= WDATA[sbl_pkg::BDH_EDGE_IE];
      end else if (wr_bdl) begin
         bdh_r[sbl_pkg::BDH_DIV_W-1:0] <=
            bdh_hold_r[sbl_pkg::BDH_DIV_W-1:0];
         bdl_r <= WDATA;
      end
   end

   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         fmt_r <= sbl_pkg::RST_FMT;
      end else if (wr_fmt) begin
         fmt_r <= WDATA;
      end
   end

   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         ena_r <= sbl_pkg::RST_ENA;
      end else if (wr_ena) begin
         ena_r <= WDATA & sbl_pkg::ENA_WMASK;
      end
   end

   // Generator held off after reset until first enable
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         armed_r <= 1'b0;
      end else if (wr_ena && (WDATA[sbl_pkg::ENA_TX] ||
                              WDATA[sbl_pkg::ENA_RX])) begin
         armed_r <= 1'b1;
      end
   end

   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         ien_r <= sbl_pkg::RST_IEN;
      end else if (wr_ien) begin
         ien_r <= WDATA[sbl_pkg::EVT_W-1:0];
      end
   end

   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         rdata_r <= 8'h00;
      end else if (RD) begin
         if (ADDR == sbl_pkg::OFF_BDH) begin
            rdata_r <= bdh_r;
         end else if (ADDR == sbl_pkg::OFF_BDL) begin
            rdata_r <= bdl_r;
         end else if (ADDR == sbl_pkg::OFF_FMT) begin
            rdata_r <= fmt_r;
         end else if (ADDR == sbl_pkg::OFF_ENA) begin
            rdata_r <= ena_r;
         end else if (ADDR == sbl_pkg::OFF_STAT) begin
            rdata_r <= {6'h00, stat_r};
         end else if (ADDR == sbl_pkg::OFF_IEN) begin
            rdata_r <= {6'h00, ien_r};
         end else begin
            rdata_r <= 8'h00;
         end
      end else begin
         rdata_r <= 8'h00;
      end
   end

   assign RDATA = rdata_r;
   assign TX_ON = ena_r[sbl_pkg::ENA_TX];
   assign RX_ON = ena_r[sbl_pkg::ENA_RX];

   // ======================================================
   // Baud generator
   // ======================================================
   assign div    = {bdh_r[sbl_pkg::BDH_DIV_W-1:0], bdl_r};
   assign frozen = fmt_r[sbl_pkg::FMT_FREEZE] & WAIT_MODE;
   assign run    = armed_r && div != 13'h0000 && !frozen;

   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         cnt_r <= 13'h0000;
      end else if (!run || tick) begin
         cnt_r <= 13'h0000;
      end else begin
         cnt_r <= cnt_r + 13'h0001;
      end
   end

   // One tick per divisor count of clocks
   assign tick = run && cnt_r >= div - 13'h0001;

   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         sub_r <= 4'h0;
      end else if (!run) begin
         sub_r <= 4'h0;
      end else if (tick) begin
         sub_r <= sub_r + 4'h1;
      end
   end

   assign BAUD_TICK = tick;
   assign BIT_TICK  = tick && sub_r == sbl_pkg::TICKS_LAST;

   // ======================================================
   // Line routing
   // ======================================================
   assign loop   = fmt_r[sbl_pkg::FMT_LOOP];
   assign single = fmt_r[sbl_pkg::FMT_SINGLE];

   always_comb begin
      if (loop && single) begin
         RX_SER = TXD_PIN_IN;
      end else if (loop) begin
         RX_SER = TX_SER;
      end else begin
         RX_SER = RXD_PIN;
      end
   end

   // Idle level high while the pin is not driven
   assign TXD_OUT  = TX_ON ? TX_SER : 1'b1;
   assign TXD_OE_N = ~TX_ON;

   // ======================================================
   // Format and parity
   // ======================================================
   assign NINE_BIT  = fmt_r[sbl_pkg::FMT_NINE];
   assign WAKE_ADDR = fmt_r[sbl_pkg::FMT_WAKE];

   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         tx_char_r <= 9'h000;
      end else if (!fmt_r[sbl_pkg::FMT_PE]) begin
         tx_char_r <= TX_DATA;
      end else if (NINE_BIT) begin
         tx_char_r <= {^TX_DATA[7:0] ^ fmt_r[sbl_pkg::FMT_PODD],
                       TX_DATA[7:0]};
      end else begin
         tx_char_r <= {TX_DATA[8], ^TX_DATA[6:0] ^
                       fmt_r[sbl_pkg::FMT_PODD],
                       TX_DATA[6:0]};
      end
   end

   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         perr_r <= 1'b0;
      end else if (!fmt_r[sbl_pkg::FMT_PE]) begin
         perr_r <= 1'b0;
      end else if (NINE_BIT) begin
         perr_r <= ^RX_CHAR ^ fmt_r[sbl_pkg::FMT_PODD];
      end else begin
         perr_r <= ^RX_CHAR[7:0] ^ fmt_r[sbl_pkg::FMT_PODD];
      end
   end

   assign TX_CHAR    = tx_char_r;
   assign PARITY_ERR = perr_r;

   // ======================================================
   // Idle line detection
   // ======================================================
   assign idle_target = NINE_BIT ? sbl_pkg::IDLE_BITS9
                                 : sbl_pkg::IDLE_BITS8;

   // After-stop mode arms only at frame end, so the stop bit
   // and trailing ones never count toward idle.
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         idle_st_r  <= SBL_IDLE_WAIT;
         idle_cnt_r <= 4'h0;
         idle_r     <= 1'b0;
      end else begin
         idle_r <= 1'b0;
         case (idle_st_r)
            SBL_IDLE_WAIT: begin
               idle_cnt_r <= 4'h0;
               if (fmt_r[sbl_pkg::FMT_ILT] ? RX_FRAME_END
                                           : !RX_SER) begin
                  idle_st_r <= SBL_IDLE_COUNT;
               end
            end
            SBL_IDLE_COUNT: begin
               if (!RX_SER) begin
                  idle_cnt_r <= 4'h0;
                  if (fmt_r[sbl_pkg::FMT_ILT]) begin
                     idle_st_r <= SBL_IDLE_WAIT;
                  end
               end else if (BIT_TICK) begin
                  if (idle_cnt_r + 4'h1 >= idle_target) begin
                     idle_r    <= 1'b1;
                     idle_st_r <= SBL_IDLE_WAIT;
                  end else begin
                     idle_cnt_r <= idle_cnt_r + 4'h1;
                  end
               end
            end
            default: begin
               idle_st_r <= SBL_IDLE_WAIT;
            end
         endcase
      end
   end

   assign IDLE_DET = idle_r;

   // ======================================================
   // Events and interrupt
   // ======================================================
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         rx_prev_r <= 1'b1;
      end else begin
         rx_prev_r <= RX_SER;
      end
   end

   assign evt[sbl_pkg::EVT_BRK]  = LIN_BREAK_EVT;
   assign evt[sbl_pkg::EVT_EDGE] = RX_ON && rx_prev_r && !RX_SER;

   // Set beats clear in the same cycle
   always_comb begin
      stat_nxt = stat_r;
      if (wr_clr) begin
         stat_nxt = stat_r & ~WDATA[sbl_pkg::EVT_W-1:0];
      end
      stat_nxt = stat_nxt | evt;
   end

   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         stat_r <= 2'h0;
      end else begin
         stat_r <= stat_nxt;
      end
   end

   assign gate = {bdh_r[sbl_pkg::BDH_BRK_IE], bdh_r[sbl_pkg::BDH_EDGE_IE]};
   assign IRQ  = |(stat_r & ien_r & gate);

   // ======================================================
   // Checks
   // ======================================================
   a_div_buffered: assert property (
      @(posedge MCLK) disable iff (!RSTN)
      wr_bdh |=> div == $past(div))
      else $error("upper divisor write changed working value");

   a_div_commit: assert property (
      @(posedge MCLK) disable iff (!RSTN)
      wr_bdl |=> div == {$past(bdh_hold_r[sbl_pkg::BDH_DIV_W-1:0]),
                         $past(WDATA)})
      else $error("lower write did not commit buffered divisor");

   a_zero_stops: assert property (
      @(posedge MCLK) disable iff (!RSTN)
      div == 13'h0000 |-> !BAUD_TICK ##1 cnt_r == 13'h0000)
      else $error("baud generator ran with zero divisor");

   a_tick_period: assert property (
      @(posedge MCLK) disable iff (!RSTN)
      BAUD_TICK && div == 13'h0003 ##1 $stable(div) && run
      |-> !BAUD_TICK ##1 !BAUD_TICK || !run || div != 13'h0003)
      else $error("baud tick came early");

   a_bit_sixteen: assert property (
      @(posedge MCLK) disable iff (!RSTN)
      BIT_TICK |-> BAUD_TICK && sub_r == sbl_pkg::TICKS_LAST)
      else $error("bit tick not on sixteenth baud tick");

   a_not_armed: assert property (
      @(posedge MCLK) disable iff (!RSTN)
      !armed_r |-> !BAUD_TICK)
      else $error("baud generator ran before first enable");

   a_break_irq: assert property (
      @(posedge MCLK) disable iff (!RSTN)
      LIN_BREAK_EVT && bdh_r[sbl_pkg::BDH_BRK_IE] &&
      ien_r[sbl_pkg::EVT_BRK] && !wr_bdh && !wr_ien |=> IRQ)
      else $error("break flag did not raise interrupt");

   a_edge_gated: assert property (
      @(posedge MCLK) disable iff (!RSTN)
      !bdh_r[6] && !(stat_r[1] && bdh_r[7]) |-> !IRQ)
      else $error("edge flag raised interrupt while gated");

   a_loop_route: assert property (
      @(posedge MCLK) disable iff (!RSTN)
      loop && !single |-> RX_SER == TX_SER)
      else $error("loop mode did not feed transmitter back");

   a_single_wire: assert property (
      @(posedge MCLK) disable iff (!RSTN)
      loop && single |-> RX_SER == TXD_PIN_IN)
      else $error("single wire mode not reading transmit pin");

   a_wait_freeze: assert property (
      @(posedge MCLK) disable iff (!RSTN)
      fmt_r[sbl_pkg::FMT_FREEZE] && WAIT_MODE |->
      !BAUD_TICK ##1 sub_r == 4'h0)
      else $error("serial clocks ran in wait mode");

   a_parity_count: assert property (
      @(posedge MCLK) disable iff (!RSTN)
      fmt_r[sbl_pkg::FMT_PE] |=>
      ($past(NINE_BIT) ? ^TX_CHAR : ^TX_CHAR[7:0]) ==
      $past(fmt_r[sbl_pkg::FMT_PODD]))
      else $error("generated parity has wrong count of ones");

   a_txd_owned: assert property (
      @(posedge MCLK) disable iff (!RSTN)
      TX_ON |-> !TXD_OE_N && TXD_OUT == TX_SER)
      else $error("transmit pin not driven while enabled");

   c_bit_tick: cover property (
      @(posedge MCLK) disable iff (!RSTN) BIT_TICK);
   c_irq_edge: cover property (
      @(posedge MCLK) disable iff (!RSTN) IRQ && stat_r[0]);
   c_idle: cover property (
      @(posedge MCLK) disable iff (!RSTN) IDLE_DET && NINE_BIT);
endmodule : sbl_top

// *** inc/sbl_pkg.sv ***
// Constants for the serial line baud and format configuration block
package sbl_pkg;
   // ======================================================
   // Register offsets
   // ======================================================
   localparam logic [2:0] OFF_BDH    = 3'h0;
   localparam logic [2:0] OFF_BDL    = 3'h1;
   localparam logic [2:0] OFF_FMT    = 3'h2;
   localparam logic [2:0] OFF_ENA    = 3'h3;
   localparam logic [2:0] OFF_STAT   = 3'h4;
   localparam logic [2:0] OFF_CLR    = 3'h5;
   localparam logic [2:0] OFF_IEN    = 3'h6;
   // ======================================================
   // Field positions
   // ======================================================
   localparam int BDH_BRK_IE  = 7;
   localparam int BDH_EDGE_IE = 6;
   localparam int BDH_DIV_W   = 5;
   localparam int FMT_LOOP    = 7;
   localparam int FMT_FREEZE  = 6;
   localparam int FMT_SINGLE  = 5;
   localparam int FMT_NINE    = 4;
   localparam int FMT_WAKE    = 3;
   localparam int FMT_ILT     = 2;
   localparam int FMT_PE      = 1;
   localparam int FMT_PODD    = 0;
   localparam int ENA_TX      = 3;
   localparam int ENA_RX      = 2;
   localparam int EVT_BRK     = 1;
   localparam int EVT_EDGE    = 0;
   localparam int DIV_W       = 13;
   localparam int EVT_W       = 2;
   // ======================================================
   // Reset values and write masks
   // ======================================================
   localparam logic [7:0] RST_BDH = 8'h00;
   localparam logic [7:0] RST_BDL = 8'h04;
   localparam logic [7:0] RST_FMT = 8'h00;
   localparam logic [7:0] RST_ENA = 8'h00;
   localparam logic [1:0] RST_IEN = 2'h3;
   localparam logic [7:0] BDH_WMASK = 8'hDF;
   localparam logic [7:0] ENA_WMASK = 8'h0C;
   // ======================================================
   // Timing
   // ======================================================
   localparam logic [3:0] TICKS_LAST = 4'hF;
   localparam logic [3:0] IDLE_BITS8 = 4'hA;
   localparam logic [3:0] IDLE_BITS9 = 4'hB;
endpackage : sbl_pkg

// *** bench/sbl_node.sv ***
// Remote serial node model that sends frames on the receive pin
`timescale 1ns/1ps
module sbl_node (
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic       bit_tick,
   input  wire logic       send,
   input  wire logic [7:0] data,
   output logic            rxd,
   output logic            busy
);
   // ==========
   // Frame shifter
   logic [9:0] sh_r;
   logic [3:0] n_r;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sh_r <= 10'h3FF;
         n_r  <= 4'h0;
      end else if (send && n_r == 4'h0) begin
         // Start, eight bits low first, stop
         sh_r <= {1'b1, data, 1'b0};
         n_r  <= 4'hA;
      end else if (bit_tick && n_r != 4'h0) begin
         // Ones fill in behind: pulled-up idle line
         sh_r <= {1'b1, sh_r[9:1]};
         n_r  <= n_r - 4'h1;
      end
   end

   assign rxd  = sh_r[0];
   assign busy = (n_r != 4'h0);
endmodule : sbl_node

// *** bench/tb.sv ***
// Self-checking bench for the baud and line format block
`timescale 1ns/1ps
module tb;
   // ==========
   // Signals
   logic       MCLK, RSTN, WR, RD, WAIT_MODE, LIN_BREAK_EVT, send;
   logic       TXD_PIN_IN, TX_SER, RX_FRAME_END, IRQ, RXD_PIN, busy;
   logic       TXD_OUT, TXD_OE_N, RX_SER, BAUD_TICK, BIT_TICK, TX_ON;
   logic       NINE_BIT, WAKE_ADDR, RX_ON, PARITY_ERR, IDLE_DET;
   logic [2:0] ADDR;
   logic [7:0] WDATA, RDATA, sdata;
   logic [8:0] TX_DATA, TX_CHAR, RX_CHAR;
   int         compares, miscompares;

   sbl_top dut (.MCLK(MCLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA),
      .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ), .WAIT_MODE(WAIT_MODE),
      .LIN_BREAK_EVT(LIN_BREAK_EVT), .RXD_PIN(RXD_PIN),
      .TXD_PIN_IN(TXD_PIN_IN), .TXD_OUT(TXD_OUT), .TXD_OE_N(TXD_OE_N),
      .TX_SER(TX_SER), .RX_SER(RX_SER), .BAUD_TICK(BAUD_TICK),
      .BIT_TICK(BIT_TICK), .NINE_BIT(NINE_BIT), .WAKE_ADDR(WAKE_ADDR),
      .TX_ON(TX_ON), .RX_ON(RX_ON), .TX_DATA(TX_DATA), .TX_CHAR(TX_CHAR),
      .RX_CHAR(RX_CHAR), .PARITY_ERR(PARITY_ERR),
      .RX_FRAME_END(RX_FRAME_END), .IDLE_DET(IDLE_DET));

   sbl_node node (.clk(MCLK), .rstn(RSTN), .bit_tick(BIT_TICK),
      .send(send), .data(sdata), .rxd(RXD_PIN), .busy(busy));

   initial begin
      MCLK = 1'b0;
      forever #5 MCLK = ~MCLK;
   end

   // ==========
   // Shared helpers
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %0t got %0h exp %0h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      ADDR  <= a;
      WDATA <= d;
      WR    <= 1'b1;
      @(posedge MCLK);
      WR <= 1'b0;
      @(posedge MCLK);
   endtask : wr

   task automatic rdchk(input logic [2:0] a, input logic [7:0] e);
      ADDR <= a;
      RD   <= 1'b1;
      @(posedge MCLK);
      RD <= 1'b0;
      @(negedge MCLK);
      chk(16'(RDATA), 16'(e));
      @(posedge MCLK);
   endtask : rdchk

   // Gap between two ticks; the first wait drops a partial period
   task automatic period(input bit bt, input logic [15:0] e);
      int n;
      repeat (2) begin
         n = 0;
         do begin
            @(negedge MCLK);
            n++;
         end while (!(bt ? BIT_TICK : BAUD_TICK) && n < 9000);
      end
      chk(16'(n), e);
      @(posedge MCLK);
   endtask : period

   task automatic nticks(input int c, input logic [15:0] e);
      int n;
      n = 0;
      @(posedge MCLK);
      repeat (c) begin
         @(negedge MCLK);
         if (BAUD_TICK === 1'b1) n++;
      end
      chk(16'(n), e);
      @(posedge MCLK);
   endtask : nticks

   task automatic tx_frame(input logic [7:0] d);
      sdata <= d;
      send  <= 1'b1;
      @(posedge MCLK);
      send <= 1'b0;
   endtask : tx_frame

   task automatic wait_node(input logic [15:0] e);
      int n, k;
      n = 0;
      k = 0;
      @(negedge MCLK);
      while (busy && k < 3000) begin
         @(negedge MCLK);
         k++;
         if (IDLE_DET === 1'b1) n++;
      end
      chk(16'(n), e);
      chk(16'(busy), 16'h0000);
      @(posedge MCLK);
   endtask : wait_node

   // Bit ticks of high line seen when the idle pulse arrives
   task automatic idle_wait(input logic [15:0] e);
      int n, k;
      n = 0;
      k = 0;
      while (IDLE_DET !== 1'b1 && k < 3000) begin
         @(negedge MCLK);
         k++;
         if (RX_SER !== 1'b1) n = 0;
         else if (BIT_TICK === 1'b1) n++;
      end
      chk(16'(n), e);
      @(posedge MCLK);
   endtask : idle_wait

   task automatic rxchk(input logic [8:0] c, input logic e);
      RX_CHAR <= c;
      @(posedge MCLK);
      @(negedge MCLK);
      chk(16'(PARITY_ERR), 16'(e));
      @(posedge MCLK);
   endtask : rxchk

   // ==========
   // Scenarios
   task automatic t_reset;
      rdchk(3'h0, sbl_pkg::RST_BDH);
      rdchk(3'h1, sbl_pkg::RST_BDL);
      rdchk(3'h2, sbl_pkg::RST_FMT);
      rdchk(3'h6, 8'h03);
      rdchk(3'h7, 8'h00);
      nticks(40, 16'h0000);
      chk(16'({TXD_OE_N, TXD_OUT}), 16'h0003);
   endtask : t_reset

   task automatic t_baud;
      wr(3'h3, 8'h04);
      chk(16'(RX_ON), 16'h0001);
      period(1'b0, 16'h0004);
      wr(3'h0, 8'h00);
      wr(3'h1, 8'h03);
      period(1'b0, 16'h0003);
      period(1'b1, 16'h0030);
      wr(3'h0, 8'h01);
      period(1'b0, 16'h0003);
      wr(3'h1, 8'h02);
      period(1'b0, 16'h0102);
      wr(3'h0, 8'h00);
      wr(3'h1, 8'h00);
      nticks(300, 16'h0000);
      wr(3'h1, 8'h03);
   endtask : t_baud

   task automatic t_freeze;
      wr(3'h2, 8'h40);
      WAIT_MODE <= 1'b1;
      nticks(30, 16'h0000);
      wr(3'h2, 8'h00);
      nticks(30, 16'h000A);
      WAIT_MODE <= 1'b0;
   endtask : t_freeze

   task automatic t_idle;
      tx_frame(8'hFF);
      idle_wait(16'h000A);
      wr(3'h2, 8'h14);
      chk(16'(NINE_BIT), 16'h0001);
      tx_frame(8'hFF);
      wait_node(16'h0000);
      RX_FRAME_END <= 1'b1;
      @(posedge MCLK);
      RX_FRAME_END <= 1'b0;
      idle_wait(16'h000B);
      wr(3'h2, 8'h00);
   endtask : t_idle

   task automatic t_irq;
      wr(3'h5, 8'h03);
      wr(3'h0, 8'h00);
      LIN_BREAK_EVT <= 1'b1;
      @(posedge MCLK);
      LIN_BREAK_EVT <= 1'b0;
      rdchk(3'h4, 8'h02);
      chk(16'(IRQ), 16'h0000);
      wr(3'h0, 8'h80);
      chk(16'(IRQ), 16'h0001);
      wr(3'h6, 8'h00);
      chk(16'(IRQ), 16'h0000);
      wr(3'h6, 8'h03);
      wr(3'h5, 8'h02);
      chk(16'(IRQ), 16'h0000);
      LIN_BREAK_EVT <= 1'b1;
      @(posedge MCLK);
      LIN_BREAK_EVT <= 1'b0;
      @(negedge MCLK);
      chk(16'(IRQ), 16'h0001);
      @(posedge MCLK);
      wr(3'h5, 8'h02);
      rdchk(3'h4, 8'h00);
      tx_frame(8'h55);
      repeat (3) @(posedge MCLK);
      chk(16'(IRQ), 16'h0000);
      rdchk(3'h4, 8'h01);
      wr(3'h0, 8'h40);
      chk(16'(IRQ), 16'h0001);
      wr(3'h5, 8'h01);
      chk(16'(IRQ), 16'h0000);
      wait_node(16'h0000);
      wr(3'h0, 8'h00);
   endtask : t_irq

   task automatic t_route;
      logic [7:0] fm [4] = '{8'h00, 8'h20, 8'h80, 8'hA0};
      logic [1:0] dv [4] = '{2'b00, 2'b00, 2'b01, 2'b10};
      logic       ex [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
      for (int i = 0; i < 4; i++) begin
         TX_SER     <= dv[i][1];
         TXD_PIN_IN <= dv[i][0];
         wr(3'h2, fm[i]);
         chk(16'(RX_SER), 16'(ex[i]));
      end
      wr(3'h2, 8'h00);
      wr(3'h3, 8'h0C);
      chk(16'(TX_ON), 16'h0001);
      for (int i = 0; i < 2; i++) begin
         TX_SER <= i[0];
         @(negedge MCLK);
         chk(16'({TXD_OE_N, TXD_OUT}), 16'(i[0]));
         @(posedge MCLK);
      end
      wr(3'h3, 8'h04);
      TX_SER <= 1'b0;
      @(negedge MCLK);
      chk(16'({TXD_OE_N, TXD_OUT}), 16'h0003);
      @(posedge MCLK);
   endtask : t_route

   task automatic t_parity;
      logic [8:0] d, e;
      logic       pe, po, nb;
      d = 9'h1A5;
      TX_DATA <= d;
      for (int f = 0; f < 8; f++) begin
         po = f[0];
         pe = f[1];
         nb = f[2];
         e  = d;
         if (pe && nb) e[8] = ^d[7:0] ^ po;
         else if (pe) e[7] = ^d[6:0] ^ po;
         wr(3'h2, {3'b000, nb, po ^ nb, 1'b0, pe, po});
         @(negedge MCLK);
         chk(16'(TX_CHAR), 16'(e));
         chk(16'({NINE_BIT, WAKE_ADDR}), 16'({nb, po ^ nb}));
         @(posedge MCLK);
         rxchk(e, 1'b0);
         rxchk(e ^ 9'h001, pe);
      end
   endtask : t_parity

   task automatic tally_and_finish;
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : tally_and_finish

   // ==========
   // Main sequence and watchdog
   initial begin
      {WR, RD, WAIT_MODE, LIN_BREAK_EVT, TXD_PIN_IN, TX_SER} = '0;
      {RX_FRAME_END, send, ADDR, WDATA, sdata, TX_DATA, RX_CHAR} = '0;
      compares    = 0;
      miscompares = 0;
      RSTN        = 1'b0;
      repeat (10) @(posedge MCLK);
      RSTN <= 1'b1;
      @(posedge MCLK);
      t_reset();
      t_baud();
      t_freeze();
      t_idle();
      t_irq();
      t_route();
      t_parity();
      tally_and_finish();
   end

   // Whole run needs some 3300 cycles; this is about six times that
   initial begin
      #200000;
      miscompares++;
      tally_and_finish();
   end
endmodule : tb
